/* design/io_state_defines.vh */
// Purpose: constants for the input-state and forced-output object block
// Assumes: object addresses are word indices on the host access port
// Notes: data words and masks are 32 bits, object addresses 16 bits, function code 6 bits
`ifndef IO_STATE_DEFINES_VH
`define IO_STATE_DEFINES_VH
`define ADDR_POSITION_DEVIATION 16'h366a
`define ADDR_POSITION_REFERENCE_ENCODER 16'h367a
`define ADDR_INPUT_STATE_WORD 16'h367c
`define ADDR_TARGET_VELOCITY 16'h3680
`define ADDR_FORCED_OUTPUT_WORD 16'h3781
`define ADDR_FORCED_OUTPUT_ENABLE_MASK 16'h3881
`define RESET_WORD 32'h00000000
`define BIT_NEG_LIMIT 0
`define BIT_POS_LIMIT 1
`define BIT_HOME 2
`define BIT_GENERAL_LO 16
`define BIT_TORQUE_OFF_FIRST 27
`define BIT_TORQUE_OFF_SECOND 28
`define BIT_RELAY_FEEDBACK 29
`define BIT_ENCODER_INDEX 30
`define BIT_FORCED_LO 16
`define NUM_FORCED 5
`define BIT_GAIN_SWITCHOVER 26
`define FORCED_FUNCTION_CODE 6'h1f
`define WRITABLE_MASK 32'h041f0000
`endif

/* design/forced_output_mux.v */
// Purpose: per-pin selection between normal and host-forced output level
// Assumes: function code per pin supplied by the configuration logic
// Notes: purely combinational; the top registers the result
`timescale 1ns/1ps
`include "io_state_defines.vh"
module forced_output_mux
(
	// per pin inputs, pin n at bits 6n+5..6n for function codes
	input wire [4:0] normal_level,
	input wire [29:0] pin_function,
	input wire [31:0] forced_word,
	input wire [31:0] enable_mask,
	// result
	output wire [4:0] pin_level
);
	genvar i;
	generate
		for (i = 0; i < `NUM_FORCED; i = i + 1)
		begin : g_pin
			wire sel;
			assign sel = (pin_function[6*i+5:6*i] == `FORCED_FUNCTION_CODE) &&
				enable_mask[`BIT_FORCED_LO+i];
			assign pin_level[i] = sel ? forced_word[`BIT_FORCED_LO+i] : normal_level[i];
		end
	endgenerate
endmodule

/* design/io_state_objects.v */
// Purpose: input-state, forced-output, position and target-velocity objects
// Assumes: host access port is synchronous, one access per strobe, read data next cycle
// Notes: clk_en low freezes all state
`timescale 1ns/1ps
`include "io_state_defines.vh"
// Function
// - input-state word shows present level of each input, 1 active
// - bit0 negative limit, bit1 positive limit, bit2 home, bits16-23 general inputs
// - pins one to five forced from bits16-20 when function 31 and enabled
// - bit26 selects gain switchover only when mask bit26 is set
// - enable mask uses bits16-20 and 26, resets to zero
// - position deviation is read-only signed 32-bit, resets to zero
// - encoder-unit position reference is read-only signed 32-bit
// - with servo enabled and no warning, encoder ref equals ref times gear ratio
module io_state_objects
(
	// clock and reset
	input wire clk,
	input wire rst,
	input wire clk_en,
	// host object access
	input wire [15:0] obj_addr,
	input wire obj_wr,
	input wire obj_rd,
	input wire [31:0] obj_wdata,
	output reg [31:0] obj_rdata,
	output reg obj_ack,
	output reg obj_err,
	// input pins and status sources
	input wire neg_limit,
	input wire pos_limit,
	input wire home_switch,
	input wire [7:0] input_pin_state,
	input wire safe_torque_off_first,
	input wire safe_torque_off_second,
	input wire relay_feedback_monitor,
	input wire encoder_index,
	// position loop sources
	input wire [31:0] position_deviation_in,
	input wire [31:0] position_reference_units,
	input wire [31:0] gear_ratio,
	input wire servo_enable,
	input wire warning_present,
	// output pin configuration and normal levels
	input wire [29:0] pin_function,
	input wire [4:0] normal_output,
	input wire normal_gain_switchover,
	// outputs
	output reg [4:0] output_pin,
	output reg gain_switchover,
	output reg [31:0] target_velocity_out
);
	reg [31:0] input_state_word_reg;
	reg [31:0] position_deviation_reg;
	reg [31:0] position_reference_encoder_reg;
	reg [31:0] target_velocity_reg;
	reg [31:0] forced_output_word_reg;
	reg [31:0] forced_output_enable_mask_reg;
	reg [31:0] input_state_next;
	reg [31:0] rdata_next;
	reg hit_next;
	wire [63:0] product;
	wire [4:0] pin_level;
	// next values of the host-writable objects, of the tracked reference and of the gain selection
	reg [31:0] target_velocity_next;
	reg [31:0] forced_output_word_next;
	reg [31:0] forced_output_enable_mask_next;
	reg [31:0] position_reference_encoder_next;
	reg gain_switchover_next;
	wire access;
	wire wr_target_velocity;
	wire wr_forced_word;
	wire wr_forced_mask;

	// input levels as seen on the pins, unused positions held at zero
	always @*
	begin
		input_state_next = `RESET_WORD;
		input_state_next[`BIT_NEG_LIMIT] = neg_limit;
		input_state_next[`BIT_POS_LIMIT] = pos_limit;
		input_state_next[`BIT_HOME] = home_switch;
		input_state_next[`BIT_GENERAL_LO+7:`BIT_GENERAL_LO] = input_pin_state;
		input_state_next[`BIT_TORQUE_OFF_FIRST] = safe_torque_off_first;
		input_state_next[`BIT_TORQUE_OFF_SECOND] = safe_torque_off_second;
		input_state_next[`BIT_RELAY_FEEDBACK] = relay_feedback_monitor;
		input_state_next[`BIT_ENCODER_INDEX] = encoder_index;
	end

	// full 64-bit signed product; the reference takes its low 32 bits, so overflow wraps
	assign product = $signed(position_reference_units) * $signed(gear_ratio);

	// read select; an unmapped address reads zero and raises the error flag
	always @*
	begin
		hit_next = 1'b1;
		case (obj_addr)
			`ADDR_POSITION_DEVIATION: rdata_next = position_deviation_reg;
			`ADDR_POSITION_REFERENCE_ENCODER: rdata_next = position_reference_encoder_reg;
			`ADDR_INPUT_STATE_WORD: rdata_next = input_state_word_reg;
			`ADDR_TARGET_VELOCITY: rdata_next = target_velocity_reg;
			`ADDR_FORCED_OUTPUT_WORD: rdata_next = forced_output_word_reg;
			`ADDR_FORCED_OUTPUT_ENABLE_MASK: rdata_next = forced_output_enable_mask_reg;
			default:
			begin
				rdata_next = `RESET_WORD;
				hit_next = 1'b0;
			end
		endcase
	end

	forced_output_mux u_mux
	(
		.normal_level(normal_output),
		.pin_function(pin_function),
		.forced_word(forced_output_word_reg),
		.enable_mask(forced_output_enable_mask_reg),
		.pin_level(pin_level)
	);

	// decoded host writes; a write to a read-only or unmapped object changes nothing
	assign access = obj_wr | obj_rd;
	assign wr_target_velocity = obj_wr && (obj_addr == `ADDR_TARGET_VELOCITY);
	assign wr_forced_word = obj_wr && (obj_addr == `ADDR_FORCED_OUTPUT_WORD);
	assign wr_forced_mask = obj_wr && (obj_addr == `ADDR_FORCED_OUTPUT_ENABLE_MASK);

	always @*
	begin
		target_velocity_next = target_velocity_reg;
		forced_output_word_next = forced_output_word_reg;
		forced_output_enable_mask_next = forced_output_enable_mask_reg;
		if (wr_target_velocity)
			target_velocity_next = obj_wdata;
		// unused bit positions never reach the registers and read back as zero
		if (wr_forced_word)
			forced_output_word_next = obj_wdata & `WRITABLE_MASK;
		if (wr_forced_mask)
			forced_output_enable_mask_next = obj_wdata & `WRITABLE_MASK;
	end

	// encoder-unit reference tracks only while the servo runs with no warning
	always @*
	begin
		if (servo_enable && !warning_present)
			position_reference_encoder_next = product[31:0];
		else
			position_reference_encoder_next = position_reference_encoder_reg;
	end

	// host may override the gain selection through mask bit 26
	always @*
	begin
		if (forced_output_enable_mask_reg[`BIT_GAIN_SWITCHOVER])
			gain_switchover_next = forced_output_word_reg[`BIT_GAIN_SWITCHOVER];
		else
			gain_switchover_next = normal_gain_switchover;
	end

	// sampled input levels and position words; none of them is host-writable
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			input_state_word_reg <= `RESET_WORD;
			position_deviation_reg <= `RESET_WORD;
			position_reference_encoder_reg <= `RESET_WORD;
		end
		else if (clk_en)
		begin
			input_state_word_reg <= input_state_next;
			position_deviation_reg <= position_deviation_in;
			position_reference_encoder_reg <= position_reference_encoder_next;
		end
	end

	// host-writable objects
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			target_velocity_reg <= `RESET_WORD;
			forced_output_word_reg <= `RESET_WORD;
			forced_output_enable_mask_reg <= `RESET_WORD;
		end
		else if (clk_en)
		begin
			target_velocity_reg <= target_velocity_next;
			forced_output_word_reg <= forced_output_word_next;
			forced_output_enable_mask_reg <= forced_output_enable_mask_next;
		end
	end

	// answer one enabled cycle after each access; read data is zero without a read
	// a read and a write in the same cycle return the value held before the write
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			obj_rdata <= `RESET_WORD;
			obj_ack <= 1'b0;
			obj_err <= 1'b0;
		end
		else if (clk_en)
		begin
			obj_ack <= access;
			obj_err <= access & ~hit_next;
			obj_rdata <= obj_rd ? rdata_next : `RESET_WORD;
		end
	end

	// pins, gain selection and velocity copy, each straight from a flip-flop
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			output_pin <= 5'h00;
			gain_switchover <= 1'b0;
			target_velocity_out <= `RESET_WORD;
		end
		else if (clk_en)
		begin
			output_pin <= pin_level;
			gain_switchover <= gain_switchover_next;
			target_velocity_out <= target_velocity_reg;
		end
	end
endmodule

/* tb/io_state_objects_assertions.sv */
// Purpose: port checks for io_state_objects
// Assumes: clk_en held high
// Notes: helper regs mirror host writes
`timescale 1ns/1ps
module io_state_objects_assertions(
	input logic clk, rst, clk_en, obj_wr, obj_rd, obj_ack, obj_err,
	input logic gain_switchover, normal_gain_switchover,
	input logic [15:0] obj_addr,
	input logic [31:0] obj_wdata, obj_rdata, target_velocity_out,
	input logic [29:0] pin_function,
	input logic [4:0] normal_output, output_pin
);
	logic [31:0] m, f, v;
	wire hit = obj_addr inside {16'h366a, 16'h367a, 16'h367c, 16'h3680, 16'h3781, 16'h3881};
	always @(posedge clk or posedge rst)
		if (rst)
			{m, f, v} <= 96'h0;
		else if (clk_en && obj_wr)
			case (obj_addr)
			16'h3881: m <= obj_wdata;
			16'h3781: f <= obj_wdata;
			16'h3680: v <= obj_wdata;
			default: v <= v;
			endcase
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_req; clk_en && (obj_wr || obj_rd); endsequence
	sequence s_rd(a); clk_en && obj_rd && obj_addr == a; endsequence
	a_ack_follows: assert property (s_req |=> obj_ack) else $error("ack");
	a_idle_quiet: assert property (clk_en && !obj_wr && !obj_rd |=> !obj_ack && obj_rdata == 0)
		else $error("idle");
	a_err_unmapped: assert property (s_req ##0 !hit |=> obj_err && obj_rdata == 0)
		else $error("err");
	a_err_mapped: assert property (s_req ##0 hit |=> !obj_err)
		else $error("err on mapped object");
	a_state_gaps: assert property (s_rd(16'h367c) |=> (obj_rdata & 32'h8700fff8) == 0)
		else $error("gap");
	a_force_gaps: assert property (s_rd(16'h3781) or s_rd(16'h3881) |=>
		(obj_rdata & 32'hfbe0ffff) == 0) else $error("unused");
	a_pin_forced: assert property (!$past(rst) |-> output_pin[0] ==
		$past(pin_function[5:0] == 6'h1f && m[16] ? f[16] : normal_output[0])) else $error("pin");
	a_gain_select: assert property (!$past(rst) |-> gain_switchover ==
		$past(m[26] ? f[26] : normal_gain_switchover)) else $error("gain");
	a_vel_follow: assert property (v == $past(v) && v == $past(v, 2) |->
		target_velocity_out == v) else $error("vel");
endmodule
bind io_state_objects io_state_objects_assertions u_chk(.*);

/* tb/host_model.sv */
// Purpose: host side of the object port
// Assumes: one access per call
// Notes: idle bus shows inverted values
`timescale 1ns/1ps
module host_model(
	input logic clk, obj_ack,
	input logic [31:0] obj_rdata,
	output logic obj_wr = 0, obj_rd = 0,
	output logic [15:0] obj_addr = 0,
	output logic [31:0] obj_wdata = 0
);
	task xfer(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		{obj_wr, obj_rd, obj_addr, obj_wdata} <= {w, !w, a, d};
		@(posedge clk);
		{obj_wr, obj_rd, obj_addr, obj_wdata} <= {2'b0, ~a, ~d};
		@(posedge clk);
		q = obj_ack ? obj_rdata : 32'hx;
	endtask
endmodule

/* tb/io_state_objects_bench.sv */
// Purpose: random run of io_state_objects
// Assumes: clk_en held high
// Notes: inputs held for each round
`timescale 1ns/1ps
module io_state_objects_bench;
	logic clk = 0, rst = 1, clk_en = 1, obj_wr, obj_rd, obj_ack, obj_err, gain_switchover;
	logic neg_limit, pos_limit, home_switch, safe_torque_off_first, safe_torque_off_second;
	logic relay_feedback_monitor, encoder_index, servo_enable, warning_present;
	logic normal_gain_switchover;
	logic [7:0] input_pin_state;
	logic [4:0] normal_output, output_pin;
	logic [15:0] obj_addr;
	logic [15:0] ad[7] = '{16'h366a, 16'h367a, 16'h367c, 16'h3680, 16'h3781, 16'h3881, 16'h3682};
	logic [22:0] r = 0;
	logic [29:0] pin_function = 0;
	logic [31:0] obj_wdata, obj_rdata, target_velocity_out, q, w, m, v, pe = 0;
	logic [31:0] position_deviation_in = 0, position_reference_units = 0, gear_ratio = 0;
	logic [31:0] exp_q[$];
	int error_cnt = 0, comparisons = 0;
	assign {neg_limit, pos_limit, home_switch, safe_torque_off_first, safe_torque_off_second,
		relay_feedback_monitor, encoder_index, servo_enable, warning_present,
		normal_gain_switchover, input_pin_state, normal_output} = r;
	always #4 clk = ~clk;
	io_state_objects u_dut(.*);
	host_model u_host(.*);
	task check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: %h not %h", $time, seen, exp);
		end
	endtask
	task close_out;
		$display("checks %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		#60000;
		error_cnt++;
		close_out;
	end
	initial
	begin
		q = $urandom(32'h113d);
		repeat (2) @(posedge clk);
		rst <= 0;
		for (int i = 3; i < 6; i++)
		begin
			u_host.xfer(0, ad[i], 0, q);
			check(q, 0);
		end
		repeat (40)
		begin
			@(posedge clk);
			r <= 23'($urandom);
			{position_deviation_in, position_reference_units, gear_ratio} <= {$urandom, $urandom, $urandom};
			for (int k = 0; k < 5; k++)
				pin_function[6 * k +: 6] <= $urandom % 2 ? 6'h1f : 6'($urandom);
			{w, m, v} = {$urandom, $urandom, $urandom};
			u_host.xfer(1, 16'h3781, w, q);
			u_host.xfer(1, 16'h3881, m, q);
			u_host.xfer(1, 16'h3680, v, q);
			for (int i = 0; i < 3; i++)
				u_host.xfer(1, ad[i], ~v, q);
			if (r[15] && !r[14])
				pe = position_reference_units * gear_ratio;
			exp_q = '{position_deviation_in, pe, {1'b0, r[16], r[17], r[18], r[19], 3'b0, r[12:5],
				13'b0, r[20], r[21], r[22]}, v, w & 32'h041f0000, m & 32'h041f0000, 32'h0};
			foreach (ad[j])
			begin
				u_host.xfer(0, ad[j], 0, q);
				check(q, exp_q.pop_front());
			end
			for (int k = 0; k < 5; k++)
				check(32'(output_pin[k]), 32'(pin_function[6 * k +: 6] == 6'h1f && m[16 + k] ?
					w[16 + k] : r[k]));
			check(32'(gain_switchover), 32'(m[26] ? w[26] : r[13]));
			check(target_velocity_out, v);
		end
		close_out;
	end
endmodule
